/* File: include/smsp_pkg.sv */
// Constants and types shared by the serial master/slave port.
`default_nettype none

package smsp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0]  IDX_CONTROL  = 10'h02C;
  localparam logic [9:0]  IDX_STATUS   = 10'h02D;
  localparam logic [9:0]  IDX_DATA     = 10'h02E;
  localparam logic [9:0]  IDX_PINCFG   = 10'h02F;
  localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_STATUS  = {IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_DATA    = {IDX_DATA, 2'h0};
  localparam logic [11:0] ADDR_PINCFG  = {IDX_PINCFG, 2'h0};

  // Control register fields.
  localparam int CTL_IE       = 7;
  localparam int CTL_EN       = 6;
  localparam int CTL_ORDER    = 5;
  localparam int CTL_MASTER_SELECT     = 4;
  localparam int CTL_CLOCK_POLARITY     = 3;
  localparam int CTL_CLOCK_PHASE     = 2;
  localparam int CTL_RATE_HI  = 1;
  localparam int CTL_RATE_LO  = 0;

  // Status register fields.
  localparam int STS_FLAG     = 7;
  localparam int STS_WRITE_COLLISION_FLAG     = 6;
  localparam int STS_DBL      = 0;

  // Pin configuration register fields.
  localparam int PIN_MOSI_DIR = 0;
  localparam int PIN_SCK_DIR  = 1;
  localparam int PIN_SS_DIR   = 2;
  localparam int PIN_MISO_DIR = 3;
  localparam int PIN_SS_VAL   = 4;
  localparam int PIN_GIE      = 7;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] PINCFG_RESET  = 8'h00;

  // Half periods of the master clock in system clocks, for each divide ratio.
  localparam logic [6:0] HALF_DIV2   = 7'h01;
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // Byte framing counts.
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [4:0] LAST_EDGE = 5'h0F;

  typedef enum logic [1:0] {XF_IDLE, XF_MASTER, XF_SLAVE} smsp_xfer_t;

  typedef struct packed {
    smsp_xfer_t  xfer;
    logic [7:0]  control;
    logic        dblSpeed;
    logic        txFlag;
    logic        write_collision_flag;
    logic        flagSeen;
    logic        wcolSeen;
    logic [7:0]  pinCfg;
    logic [7:0]  shifter;
    logic [7:0]  rxBuf;
    logic [3:0]  bitCnt;
    logic [4:0]  edgeCnt;
    logic [6:0]  divCnt;
    logic        sckLevel;
    logic        outBit;
    logic        sckMeta;
    logic        sckSync;
    logic        sckPrev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sckOut;
    logic        sckOeN;
    logic        mosiOut;
    logic        mosiOeN;
    logic        misoOut;
    logic        misoOeN;
    logic        ssOut;
    logic        ssOeN;
  } smsp_state_t;

endpackage : smsp_pkg

`default_nettype wire

/* File: rtl/smsp_port.sv */
// Byte-wide full-duplex serial master/slave port with an APB register slave.
`timescale 1ns/1ps
`default_nettype none

module smsp_port
  import smsp_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  // Interrupt request and vector acknowledge.
  input  wire logic        intAck,
  output wire logic        irq,
  // Serial clock pin.
  input  wire logic        sckIn,
  output wire logic        sckOut,
  output wire logic        sckOeN,
  // Master-out slave-in pin.
  input  wire logic        mosiIn,
  output wire logic        mosiOut,
  output wire logic        mosiOeN,
  // Master-in slave-out pin.
  input  wire logic        misoIn,
  output wire logic        misoOut,
  output wire logic        misoOeN,
  // Active-low slave-select pin.
  input  wire logic        ssIn,
  output wire logic        ssOut,
  output wire logic        ssOeN
);

  // Selects the bit that goes out next for the chosen bit order.
  function automatic logic outSel(input logic lsbFirst, input logic [7:0] sh);
    outSel = lsbFirst ? sh[0] : sh[7];
  endfunction : outSel

  // Shifts one sampled bit into the register from the matching end.
  function automatic logic [7:0] shiftIn(input logic lsbFirst, input logic [7:0] sh,
                                         input logic b);
    shiftIn = lsbFirst ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shiftIn

  // Half period of the master clock for the rate code and doubling bit.
  function automatic logic [6:0] halfPeriod(input logic dbl, input logic [1:0] rate);
    case ({dbl, rate})
      3'b000:  halfPeriod = HALF_DIV4;
      3'b001:  halfPeriod = HALF_DIV16;
      3'b010:  halfPeriod = HALF_DIV64;
      3'b011:  halfPeriod = HALF_DIV128;
      3'b100:  halfPeriod = HALF_DIV2;
      3'b101:  halfPeriod = HALF_DIV8;
      3'b110:  halfPeriod = HALF_DIV32;
      default: halfPeriod = HALF_DIV64;
    endcase
  endfunction : halfPeriod

  smsp_state_t s;
  smsp_state_t next_s;

  // Next-state logic for bus, flags, shift engine and pins.
  always_comb begin
    logic       setupPh;
    logic       accessPh;
    logic       enabled;
    logic       isMaster;
    logic       lsbFirst;
    logic       clock_polarity;
    logic       clock_phase;
    logic       slvLead;
    logic       slvTrail;
    logic       sampleE;
    logic       setupE;
    logic       setFlag;
    logic       lead;
    logic [7:0] shifted;
    logic [6:0] half;
    next_s   = s;
    setupPh  = psel && !penable;
    accessPh = psel && penable && s.pready;
    enabled  = s.control[CTL_EN];
    isMaster = s.control[CTL_MASTER_SELECT];
    lsbFirst = s.control[CTL_ORDER];
    clock_polarity     = s.control[CTL_CLOCK_POLARITY];
    clock_phase     = s.control[CTL_CLOCK_PHASE];
    setFlag  = 1'b0;
    sampleE  = 1'b0;
    setupE   = 1'b0;
    lead     = 1'b0;
    shifted  = 8'h00;
    half     = halfPeriod(s.dblSpeed, s.control[CTL_RATE_HI:CTL_RATE_LO]);

    // Slave clock passes two flip-flops, then the edge detector looks at the synced copies.
    next_s.sckMeta = sckIn;
    next_s.sckSync = s.sckMeta;
    next_s.sckPrev = s.sckSync;
    slvLead  = (s.sckPrev == clock_polarity) && (s.sckSync != clock_polarity);
    slvTrail = (s.sckPrev != clock_polarity) && (s.sckSync == clock_polarity);

    // Read data is captured in the setup cycle and answered with pready one cycle later.
    next_s.pready  = setupPh;
    next_s.pslverr = 1'b0;
    if (setupPh) begin
      case (paddr)
        ADDR_CONTROL: next_s.prdata = {24'h000000, s.control};
        ADDR_STATUS:  next_s.prdata = {24'h000000, s.txFlag, s.write_collision_flag, 5'h00, s.dblSpeed};
        ADDR_DATA:    next_s.prdata = {24'h000000, s.rxBuf};
        ADDR_PINCFG:  next_s.prdata = {24'h000000, s.pinCfg};
        default: begin
          next_s.prdata  = 32'h00000000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    // Register writes and access side effects take place at the completing edge.
    if (accessPh) begin
      if (!pwrite && paddr == ADDR_STATUS) begin
        next_s.flagSeen = s.prdata[STS_FLAG];
        next_s.wcolSeen = s.prdata[STS_WRITE_COLLISION_FLAG];
      end
      if (paddr == ADDR_DATA) begin
        if (s.flagSeen || s.wcolSeen) begin
          next_s.txFlag = 1'b0;
        end
        if (s.wcolSeen) begin
          next_s.write_collision_flag = 1'b0;
        end
        next_s.flagSeen = 1'b0;
        next_s.wcolSeen = 1'b0;
      end
      if (pwrite) begin
        case (paddr)
          ADDR_CONTROL: next_s.control = pwdata[7:0];
          ADDR_STATUS:  next_s.dblSpeed = pwdata[STS_DBL];
          ADDR_PINCFG:  next_s.pinCfg = pwdata[7:0];
          ADDR_DATA: begin
            if (s.xfer != XF_IDLE) begin
              next_s.write_collision_flag = 1'b1;
            end else begin
              next_s.shifter = pwdata[7:0];
              next_s.outBit  = outSel(lsbFirst, pwdata[7:0]);
              if (enabled && isMaster) begin
                next_s.xfer     = XF_MASTER;
                next_s.divCnt   = half;
                next_s.edgeCnt  = 5'h00;
                next_s.sckLevel = clock_polarity;
              end
            end
          end
          default: next_s.pslverr = 1'b0;
        endcase
      end
    end
    if (intAck) begin
      next_s.txFlag = 1'b0;
    end

    // Shift engine; every event that raises a flag follows the clears so the set wins.
    if (!enabled) begin
      next_s.xfer   = XF_IDLE;
      next_s.bitCnt = 4'h0;
    end else if (isMaster && !s.pinCfg[PIN_SS_DIR] && !ssIn) begin
      next_s.control[CTL_MASTER_SELECT] = 1'b0;
      next_s.xfer              = XF_IDLE;
      next_s.bitCnt            = 4'h0;
      setFlag                  = 1'b1;
    end else if (!isMaster) begin
      if (ssIn) begin
        next_s.xfer   = XF_IDLE;
        next_s.bitCnt = 4'h0;
        if (s.bitCnt != 4'h0) begin
          next_s.shifter = 8'h00;
        end
      end else begin
        sampleE = clock_phase ? slvTrail : slvLead;
        setupE  = clock_phase ? slvLead : slvTrail;
        shifted = shiftIn(lsbFirst, s.shifter, mosiIn);
        if (setupE) begin
          next_s.outBit = outSel(lsbFirst, s.shifter);
          if (clock_phase) begin
            next_s.xfer = XF_SLAVE;
          end
        end
        if (sampleE) begin
          next_s.shifter = shifted;
          if (s.bitCnt == LAST_BIT) begin
            next_s.rxBuf  = shifted;
            next_s.bitCnt = 4'h0;
            next_s.xfer   = XF_IDLE;
            setFlag       = 1'b1;
          end else begin
            next_s.bitCnt = s.bitCnt + 4'h1;
            next_s.xfer   = XF_SLAVE;
          end
        end
      end
    end else begin
      case (s.xfer)
        XF_MASTER: begin
          if (s.divCnt == 7'h01) begin
            next_s.divCnt   = half;
            next_s.sckLevel = !s.sckLevel;
            lead            = !s.edgeCnt[0];
            shifted         = shiftIn(lsbFirst, s.shifter, misoIn);
            if (lead ^ clock_phase) begin
              next_s.shifter = shifted;
            end else begin
              next_s.outBit = outSel(lsbFirst, s.shifter);
            end
            next_s.edgeCnt = s.edgeCnt + 5'h01;
            if (s.edgeCnt == LAST_EDGE) begin
              next_s.rxBuf = (lead ^ clock_phase) ? shifted : s.shifter;
              next_s.xfer  = XF_IDLE;
              setFlag      = 1'b1;
            end
          end else begin
            next_s.divCnt = s.divCnt - 7'h01;
          end
        end
        XF_IDLE:  next_s.sckLevel = next_s.sckLevel;
        default:  next_s.xfer = XF_IDLE;
      endcase
    end
    if (setFlag) begin
      next_s.txFlag = 1'b1;
    end

    // Pin drives follow the configuration that takes effect at this edge.
    next_s.sckOut  = (next_s.xfer == XF_MASTER) ? next_s.sckLevel
                                                : next_s.control[CTL_CLOCK_POLARITY];
    next_s.sckOeN  = !(next_s.control[CTL_EN] && next_s.control[CTL_MASTER_SELECT]
                       && next_s.pinCfg[PIN_SCK_DIR]);
    next_s.mosiOut = next_s.outBit;
    next_s.mosiOeN = !(next_s.control[CTL_EN] && next_s.control[CTL_MASTER_SELECT]
                       && next_s.pinCfg[PIN_MOSI_DIR]);
    next_s.misoOut = next_s.outBit;
    next_s.misoOeN = !(next_s.control[CTL_EN] && !next_s.control[CTL_MASTER_SELECT] && !ssIn
                       && next_s.pinCfg[PIN_MISO_DIR]);
    next_s.ssOut   = next_s.pinCfg[PIN_SS_VAL];
    next_s.ssOeN   = !(next_s.control[CTL_EN] && next_s.control[CTL_MASTER_SELECT]
                       && next_s.pinCfg[PIN_SS_DIR]);
    next_s.irq     = next_s.control[CTL_IE] && next_s.txFlag
                     && next_s.pinCfg[PIN_GIE];
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge clk) begin
    if (rst) begin
      s         <= '0;
      s.xfer    <= XF_IDLE;
      s.control <= CONTROL_RESET;
      s.pinCfg  <= PINCFG_RESET;
      s.sckOeN  <= 1'b1;
      s.mosiOeN <= 1'b1;
      s.misoOeN <= 1'b1;
      s.ssOeN   <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign irq     = s.irq;
  assign sckOut  = s.sckOut;
  assign sckOeN  = s.sckOeN;
  assign mosiOut = s.mosiOut;
  assign mosiOeN = s.mosiOeN;
  assign misoOut = s.misoOut;
  assign misoOeN = s.misoOeN;
  assign ssOut   = s.ssOut;
  assign ssOeN   = s.ssOeN;

  // Checks on the behaviour above.
  a_reserved_read_zero: assert property (@(posedge clk) disable iff (rst)
    (psel && penable && pready && !pwrite && paddr == ADDR_STATUS) |-> (prdata[5:1] == 5'h00))
    else $error("Reserved status bits read non-zero.");

  a_slave_ss_input: assert property (@(posedge clk) disable iff (rst)
    !s.control[CTL_MASTER_SELECT] |-> ssOeN)
    else $error("Slave-select driven while in slave mode.");

  a_deselect_miso_off: assert property (@(posedge clk) disable iff (rst)
    ($past(ce) && $past(ssIn) && !$past(s.control[CTL_MASTER_SELECT])) |-> misoOeN)
    else $error("Data-out driven while deselected.");

  a_deselect_count_reset: assert property (@(posedge clk) disable iff (rst)
    ($past(ce) && $past(ssIn) && !$past(s.control[CTL_MASTER_SELECT])) |-> (s.bitCnt == 4'h0))
    else $error("Slave bit counter survived deselect.");

  a_demote_sets_flag: assert property (@(posedge clk) disable iff (rst)
    ($past(ce) && $past(s.control[CTL_EN] && s.control[CTL_MASTER_SELECT]
     && !s.pinCfg[PIN_SS_DIR] && !ssIn))
    |-> (!s.control[CTL_MASTER_SELECT] && s.txFlag && sckOeN && mosiOeN))
    else $error("Select-low demotion incomplete.");

  a_disabled_idle: assert property (@(posedge clk) disable iff (rst)
    ($past(ce) && !$past(s.control[CTL_EN])) |-> (s.xfer == XF_IDLE))
    else $error("Transfer active while port disabled.");

  a_irq_gating: assert property (@(posedge clk) disable iff (rst)
    irq |-> (s.control[CTL_IE] && s.txFlag && s.pinCfg[PIN_GIE]))
    else $error("Interrupt raised without all enables.");

  a_collision_flag: assert property (@(posedge clk) disable iff (rst)
    ($past(ce) && $past(psel && penable && pready && pwrite && paddr == ADDR_DATA)
     && $past(s.xfer) != XF_IDLE) |-> s.write_collision_flag)
    else $error("Collision flag not set on busy write.");

  a_master_idle_level: assert property (@(posedge clk) disable iff (rst)
    (s.xfer != XF_MASTER) |-> (sckOut == s.control[CTL_CLOCK_POLARITY]))
    else $error("Clock not at idle level.");

  a_master_byte_end: assert property (@(posedge clk) disable iff (rst)
    ($past(ce) && $past(s.xfer) == XF_MASTER && s.xfer == XF_IDLE && s.control[CTL_MASTER_SELECT])
    |-> ($past(s.edgeCnt) == LAST_EDGE && s.txFlag))
    else $error("Master byte ended off the sixteenth edge.");

endmodule : smsp_port

`default_nettype wire

/* File: test/smsp_slave_model.sv */
// Behavioural serial peripheral that answers the port while it is master.
`timescale 1ns/1ps
`default_nettype none

module smsp_slave_model (
  // Serial pins.
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ssN,
  output var  logic       miso,
  // Format and data.
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsbFirst,
  input  wire logic [7:0] txByte,
  output var  logic [7:0] rxByte
);
  int s;

  // Returns the bit that goes out in slot i.
  function automatic logic pick(input int i);
    return lsbFirst ? txByte[i] : txByte[7 - i];
  endfunction : pick

  // Start quiet so no edge is taken before the first selection.
  initial begin
    s      = 8;
    miso   = 1'b0;
    rxByte = 8'h00;
  end

  // Selection restarts the byte; a released line shows a changed level.
  always @(ssN) begin
    if (!ssN) begin
      s = 0;
      if (!clock_phase) miso = pick(0);
    end else begin
      miso = ~miso;
    end
  end

  // Sample on one edge and set up the next bit on the other.
  always @(sck) begin
    if (!ssN && s < 8) begin
      if (sck == !(clock_polarity ^ clock_phase)) begin
        rxByte[lsbFirst ? s : 7 - s] = mosi;
        s = s + 1;
      end else begin
        miso = pick(s);
      end
    end
  end
endmodule : smsp_slave_model

`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the serial master/slave port.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import smsp_pkg::*;
;
  localparam logic [31:0] MPINS = 32'h07; // Data, clock and select driven.
  localparam logic [31:0] SSHI  = 32'h1 << PIN_SS_VAL;
  logic        clk, rst, ce, psel, penable, pwrite, intAck, tbSck, tbMosi, tbSs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rErr, irq, sckOut, sckOeN, mosiOut, mosiOeN;
  logic        misoOut, misoOeN, ssOut, ssOeN, sckW, mosiW, misoW, ssW;
  logic        modelMiso, clock_polarity, clock_phase, lsb, lastSck;
  logic [7:0]  modelTx, modelRx;
  int          errCount, nCompared, cyc, edges;

  // Each wire carries whoever drives it.
  assign sckW  = sckOeN ? tbSck : sckOut;
  assign mosiW = mosiOeN ? tbMosi : mosiOut;
  assign misoW = misoOeN ? modelMiso : misoOut;
  assign ssW   = ssOeN ? tbSs : ssOut;

  smsp_port smsp_port_inst (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .intAck, .irq, .sckIn(sckW), .sckOut, .sckOeN,
    .mosiIn(mosiW), .mosiOut, .mosiOeN, .misoIn(misoW), .misoOut, .misoOeN,
    .ssIn(ssW), .ssOut, .ssOeN);

  smsp_slave_model smsp_slave_model_inst (.sck(sckW), .mosi(mosiW), .ssN(ssW),
    .miso(modelMiso), .clock_polarity, .clock_phase, .lsbFirst(lsb), .txByte(modelTx), .rxByte(modelRx));

  // System clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts cycles and clock pin edges, and cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lastSck <= sckOut;
    if (sckOut !== lastSck) edges <= edges + 1;
    if (cyc == 60000) begin
      errCount++;
      end_of_test();
    end
  end

  // Prints the verdict and stops.
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Compares one value.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus transfer; read data and error land in rd and rErr.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Polls status until the complete flag shows.
  task automatic waitFlag;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[STS_FLAG] !== 1'b1 && n < 400);
    chk("complete flag", 32'h1, {31'h0, rd[STS_FLAG]});
  endtask : waitFlag

  // Waits for the clock pin to change and returns the cycle.
  task automatic waitSck(output int t);
    logic s0;
    int   n;
    s0 = sckOut;
    n  = 0;
    while (sckOut === s0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    t = cyc;
  endtask : waitSck

  // Waits for the interrupt line to reach v and checks it.
  task automatic waitIrq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("irq", {31'h0, v}, {31'h0, irq});
  endtask : waitIrq

  // Reset values, read-only bits and an unmapped address.
  task automatic t_regs;
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("control reset", {24'h0, CONTROL_RESET}, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", {24'h0, STATUS_RESET}, rd);
    apb(1'b1, ADDR_STATUS, 32'hFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status read only", 32'h1, rd);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rErr});
  endtask : t_regs

  // Master bytes in every mode and both bit orders.
  task automatic t_modes;
    int e0;
    for (int m = 0; m < 8; m++) begin
      clock_polarity = m[1];
      clock_phase = m[0];
      lsb = m[2];
      modelTx = 8'h3C + 8'(m);
      apb(1'b1, ADDR_CONTROL, 32'h51 | m[2] << CTL_ORDER | m[1] << CTL_CLOCK_POLARITY | m[0] << CTL_CLOCK_PHASE);
      apb(1'b1, ADDR_PINCFG, MPINS);
      @(posedge clk); // Pin outputs launched by the write are visible from here.
      chk("select out", 32'h0, {31'h0, ssW});
      chk("sck idle", {31'h0, clock_polarity}, {31'h0, sckOut});
      e0 = edges;
      apb(1'b1, ADDR_DATA, {24'h0, 8'hA5 ^ 8'(m * 17)});
      waitFlag();
      chk("sck edges", 32'd16, edges - e0);
      chk("peer rx", {24'h0, 8'hA5 ^ 8'(m * 17)}, {24'h0, modelRx});
      apb(1'b0, ADDR_DATA, 32'h0);
      chk("data read", {24'h0, modelTx}, rd);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("flag cleared", 32'h0, rd);
      apb(1'b1, ADDR_PINCFG, MPINS | SSHI);
    end
  endtask : t_modes

  // Half period of the master clock for every rate code.
  task automatic t_rates;
    int divs[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    int t0, t1;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_STATUS, {31'h0, c[2]});
      apb(1'b1, ADDR_CONTROL, 32'h50 | c[1:0]);
      apb(1'b1, ADDR_DATA, 32'h5A);
      waitSck(t0);
      waitSck(t1);
      chk("half period", divs[c] / 2, t1 - t0);
      waitFlag();
      apb(1'b0, ADDR_DATA, 32'h0);
    end
  endtask : t_rates

  // A data write during a byte is refused and flagged.
  task automatic t_coll;
    {clock_polarity, clock_phase, lsb} = 3'h0;
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h53);
    apb(1'b1, ADDR_PINCFG, MPINS);
    apb(1'b1, ADDR_DATA, 32'hC3);
    apb(1'b1, ADDR_DATA, 32'h18);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("collision", 32'h40, rd);
    waitFlag();
    chk("first byte kept", 32'hC3, {24'h0, modelRx});
    apb(1'b0, ADDR_DATA, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("flags cleared", 32'h0, rd);
    apb(1'b1, ADDR_PINCFG, MPINS | SSHI);
  endtask : t_coll

  // Select pulled low demotes the master and requests an interrupt.
  task automatic t_demote;
    apb(1'b1, ADDR_PINCFG, 32'h83); // Select as input, global enable on.
    apb(1'b1, ADDR_CONTROL, 32'hD0);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("master kept", 32'hD0, rd);
    tbSs <= 1'b0;
    waitIrq(1'b1);
    chk("pins released", 32'h3, {30'h0, sckOeN, mosiOeN});
    tbSs <= 1'b1;
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("master cleared", 32'hC0, rd);
    apb(1'b1, ADDR_CONTROL, 32'h40);
    waitIrq(1'b0);
    apb(1'b1, ADDR_CONTROL, 32'hC0);
    waitIrq(1'b1);
    @(posedge clk) intAck <= 1'b1;
    @(posedge clk) intAck <= 1'b0;
    waitIrq(1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("flag acked", 32'h0, rd);
  endtask : t_demote

  // Without the enable bit a data write starts no byte.
  task automatic t_off;
    int e0;
    apb(1'b1, ADDR_CONTROL, 32'h10);
    apb(1'b1, ADDR_PINCFG, MPINS);
    e0 = edges;
    apb(1'b1, ADDR_DATA, 32'hA5);
    repeat (150) @(posedge clk);
    chk("no edges", 32'h0, edges - e0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("no flag", 32'h0, rd);
  endtask : t_off

  // Plays master on the pins in mode 0, returning what the port sent.
  task automatic slvBits(input logic [7:0] b, input int n, output logic [7:0] got);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) tbMosi <= b[7 - i];
      repeat (6) @(posedge clk);
      got[7 - i] = misoW;
      tbSck <= 1'b1;
      repeat (6) @(posedge clk);
      tbSck <= 1'b0;
    end
  endtask : slvBits

  // Slave byte after an aborted partial one.
  task automatic t_slave;
    logic [7:0] seen;
    apb(1'b1, ADDR_CONTROL, 32'h43); // Rate bits set but unused.
    apb(1'b1, ADDR_PINCFG, 32'h08);
    apb(1'b1, ADDR_DATA, 32'h96);
    tbSs <= 1'b0;
    slvBits(8'hFF, 3, seen);
    @(posedge clk) tbSs <= 1'b1;
    repeat (6) @(posedge clk);
    chk("miso released", 32'h1, {31'h0, misoOeN});
    apb(1'b1, ADDR_DATA, 32'h96);
    tbSs <= 1'b0;
    repeat (6) @(posedge clk);
    chk("miso driven", 32'h0, {31'h0, misoOeN});
    slvBits(8'h4B, 8, seen);
    waitFlag();
    chk("slave sent", 32'h96, {24'h0, seen});
    apb(1'b0, ADDR_DATA, 32'h0);
    chk("slave rx", 32'h4B, rd);
    tbSs <= 1'b1;
  endtask : t_slave

  // Main sequence.
  initial begin
    {rst, ce, tbSs} = 3'h7;
    {psel, penable, pwrite, intAck, tbSck, tbMosi, clock_polarity, clock_phase, lsb, lastSck} = 10'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    modelTx = 8'h00;
    {errCount, nCompared, cyc, edges} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_rates();
    t_coll();
    t_demote();
    t_off();
    t_slave();
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
